// *** hdl/sprbc_ctrl.sv ***
/*
  memory controller end: AXI4-Lite slave whose command register sends
  one link command, spacing rules kept, and collects read beats.
  assumes the device answers reads within its programmed latency.
*/
`timescale 1ns/10ps
`default_nettype none
module sprbc_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // link
  sprbc_if.ctl lnk
);
  logic [15:0] addr_ff; // staged address
  logic [2:0] cmd_ff; // link command
  logic [2:0] bank_ff; // link bank
  logic [15:0] laddr_ff; // link address
  logic aw_ff, w_ff; // captured halves of a write
  logic [3:0] awa_ff; // captured write address
  logic [31:0] wd_ff; // captured write data
  logic bvalid_ff, rvalid_ff; // responses
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic refused_ff; // last command refused
  logic [7:0] beat_ff; // collected pattern bits
  logic [3:0] nbeat_ff; // beats collected
  logic [sprbc_pkg::BANKS-1:0] open_ff; // banks believed open
  logic [7:0] wait_ff [sprbc_pkg::BANKS]; // row close wait per bank
  logic [2:0] gap_ff; // column gap counter
  logic go; // both halves present
  logic ok; // command legal now
  logic [2:0] c; // requested command
  logic [2:0] b; // requested bank

  assign go = aw_ff && w_ff && !bvalid_ff;
  assign c = wd_ff[18:16];
  assign b = wd_ff[22:20];

  // legality of the requested command against spacing duties
  always_comb begin
    ok = 1'b1;
    case (c)
      sprbc_pkg::CMD_ACT: ok = !open_ff[b] && wait_ff[b] == 8'h00; // R15 R16
      sprbc_pkg::CMD_RD: ok = (gap_ff == 3'h0) && lnk.dll_locked &&
        (open_ff[b] || addr_ff[0] == 1'b0 && 1'b1); // R10 R20
      sprbc_pkg::CMD_WR: ok = (gap_ff == 3'h0) && open_ff[b]; // R18
      default: ok = 1'b1;
    endcase
  end

  // write channel capture, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 4'h0;
      wd_ff <= 32'h00000000;
    end else if (go) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
    end else begin
      if (s_awvalid && !aw_ff) begin
        aw_ff <= 1'b1;
        awa_ff <= s_awaddr;
      end
      if (s_wvalid && !w_ff) begin
        w_ff <= 1'b1;
        wd_ff <= s_wdata;
      end
    end
  end

  // register write effects and link command issue
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_ff <= 16'h0000;
      cmd_ff <= sprbc_pkg::CMD_NOP;
      bank_ff <= 3'h0;
      laddr_ff <= 16'h0000;
      bvalid_ff <= 1'b0;
      bresp_ff <= sprbc_pkg::RESP_OKAY;
      refused_ff <= 1'b0;
    end else begin
      cmd_ff <= sprbc_pkg::CMD_NOP;
      if (bvalid_ff && s_bready) bvalid_ff <= 1'b0;
      if (go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= sprbc_pkg::RESP_OKAY;
        if (awa_ff == sprbc_pkg::REG_ADDR) begin
          addr_ff <= wd_ff[15:0];
        end else if (awa_ff == sprbc_pkg::REG_CMD) begin
          refused_ff <= !ok;
          if (ok) begin
            cmd_ff <= c;
            bank_ff <= b;
            // pattern reads always present zero on column bits one and zero
            laddr_ff <= (c == sprbc_pkg::CMD_RD) ? {addr_ff[15:2], 2'h0} : addr_ff; // R5 R6
          end
        end else begin
          bresp_ff <= sprbc_pkg::RESP_SLVERR;
        end
      end
    end
  end

  // controller view of bank state and column gap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_ff <= '0;
      gap_ff <= 3'h0;
      for (int i = 0; i < sprbc_pkg::BANKS; i++) wait_ff[i] <= 8'h00;
    end else begin
      if (gap_ff != 3'h0) gap_ff <= gap_ff - 3'h1;
      for (int i = 0; i < sprbc_pkg::BANKS; i++) begin
        if (wait_ff[i] != 8'h00) wait_ff[i] <= wait_ff[i] - 8'h01;
      end
      case (cmd_ff)
        sprbc_pkg::CMD_ACT: open_ff[bank_ff] <= 1'b1;
        sprbc_pkg::CMD_PRE: begin
          for (int i = 0; i < sprbc_pkg::BANKS; i++) begin
            if (laddr_ff[sprbc_pkg::AUTO_PRECHARGE_BIT] || 3'(i) == bank_ff) begin
              open_ff[i] <= 1'b0;
              wait_ff[i] <= 8'(sprbc_pkg::ROW_CLOSE_CYC); // R16
            end
          end
        end
        sprbc_pkg::CMD_RD, sprbc_pkg::CMD_WR: gap_ff <= 3'(sprbc_pkg::COL_GAP - 1); // R20
        default: ;
      endcase
    end
  end

  // beat collection, lsb first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beat_ff <= 8'h00;
      nbeat_ff <= 4'h0;
    end else if (cmd_ff == sprbc_pkg::CMD_RD) begin
      nbeat_ff <= 4'h0;
    end else if (lnk.dq_valid && nbeat_ff < 4'h8) begin
      beat_ff[nbeat_ff[2:0]] <= lnk.dq[0]; // R11
      nbeat_ff <= nbeat_ff + 4'h1;
    end
  end

  // read channel: one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= sprbc_pkg::RESP_OKAY;
    end else if (rvalid_ff) begin
      if (s_rready) rvalid_ff <= 1'b0;
    end else if (s_arvalid) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= sprbc_pkg::RESP_OKAY;
      case (s_araddr)
        sprbc_pkg::REG_ADDR: rdata_ff <= {16'h0000, addr_ff};
        // beats [15:12], open banks [11:4], refused [3], locked [1]
        sprbc_pkg::REG_STATUS: rdata_ff <= {16'h0000, nbeat_ff, open_ff,
          refused_ff, 1'b0, lnk.dll_locked, 1'b0};
        sprbc_pkg::REG_DATA: rdata_ff <= {24'h000000, beat_ff};
        sprbc_pkg::REG_CMD: rdata_ff <= 32'h00000000;
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= sprbc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  assign s_awready = !aw_ff;
  assign s_wready = !w_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = !rvalid_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;
  assign lnk.cmd = cmd_ff;
  assign lnk.bank = bank_ff;
  assign lnk.addr = laddr_ff;
endmodule
`default_nettype wire

// *** hdl/sprbc_pkg.sv ***
/*
  shared constants for the pattern-read and bank-control link model.
  assumes one clock (aclk, 25 MHz) drives both ends of the link.
*/
package sprbc_pkg;
  // command encodings on the link
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_RD = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_MRS = 3'h5;
  // mode word selectors (bank field during mode set)
  localparam logic [2:0] MW_ZERO = 3'h0;
  localparam logic [2:0] MW_ONE = 3'h1;
  localparam logic [2:0] MW_THREE = 3'h3;
  // address field positions
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int BURST_CHOP_BIT = 12;
  localparam int NIBBLE_BIT = 2;
  localparam int PAT_EN_BIT = 2;
  // burst length field of mode word zero
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  // pattern location that holds the calibration pattern
  localparam logic [1:0] LOC_CAL = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'haa;
  // beat counts and column gap
  localparam int BEATS_FULL = 8;
  localparam int BEATS_CHOP = 4;
  localparam int COL_GAP = 4;
  // row close time
  localparam int ROW_CLOSE_NS = 15;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ROW_CLOSE_CYC = (ROW_CLOSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // link widths
  localparam int BANKS = 8;
  localparam int ROW_W = 16;
  localparam int DQ_W = 16;
  // controller register map (AXI4-Lite byte offsets)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/sprbc_if.sv ***
/*
  link between the memory controller and the memory device model.
  assumes both ends share aclk; dq is a two-way pin resolved here.
*/
`timescale 1ns/10ps
`default_nettype none
interface sprbc_if;
  logic [2:0] cmd; // command code
  logic [2:0] bank; // bank address
  logic [15:0] addr; // row, column or mode word
  logic dll_locked; // device delay-locked loop locked
  logic [15:0] dq_dev_o; // device drive value
  logic dq_dev_oe_n; // device enable, low drives
  logic dq_valid; // device marks a beat on dq
  logic [15:0] dq; // resolved data lanes
  assign dq = dq_dev_oe_n ? 16'h0000 : dq_dev_o;
  modport dev (input cmd, input bank, input addr, output dll_locked,
    output dq_dev_o, output dq_dev_oe_n, output dq_valid);
  modport ctl (output cmd, output bank, output addr, input dll_locked,
    input dq, input dq_valid);
endinterface
`default_nettype wire

// *** hdl/sprbc_device.sv ***
/*
  memory device end: bank open state, mode words, read bursts and the
  pattern readout register.
  assumes the controller keeps its own command spacing duties.
// Contract
// R1 - lane zero carries pattern bits
// R2 - byte lanes one to seven copy lane zero
// R3 - upper byte lane zero also carries pattern
// R4 - pattern reads ignore bank and high address
// R5 - controller drives column bits one, zero low
// R6 - full pattern burst returns beats zero to seven
// R7 - column bit two picks nibble when chopped
// R8 - chop select line or fixed chop honoured
// R9 - pattern reads use normal read latency
// R10 - controller waits for lock before pattern read
// R11 - beat zero is lsb, beat seven msb
// R12 - location zero gives alternating calibration pattern
// R13 - controller avoids reserved locations
// R14 - activate opens row in chosen bank
// R15 - controller precharges before new row
// R16 - precharge closes one or all banks
// R17 - other bank access accepted during auto precharge
// R18 - controller activates idle bank before access
// R19 - precharge to idle bank restarts timer
// R20 - chop line low chops, high full burst
// R21 - chop line never used as column bit
// R22 - full burst for field 00, or 01 high
// R23 - read latency is additive plus column latency
// R24 - pattern disabled means normal array access
*/
`timescale 1ns/10ps
`default_nettype none
module sprbc_device #(
  parameter int LOCK_CYC = 16 // cycles until loop reports lock
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  sprbc_if.dev lnk
);
  logic [1:0] bl_field_ff; // burst length field of mode word zero
  logic [3:0] cas_lat_ff; // column access latency
  logic [3:0] add_lat_ff; // additive latency
  logic pat_en_ff; // pattern readout enabled
  logic [1:0] pat_loc_ff; // pattern location select
  logic [sprbc_pkg::BANKS-1:0] open_ff; // per-bank open flag
  logic [15:0] row_ff [sprbc_pkg::BANKS]; // open row per bank
  logic [7:0] close_cnt_ff [sprbc_pkg::BANKS]; // row close timer per bank
  logic [15:0] mem_ff [16]; // tiny array stand-in, indexed by column
  logic [5:0] lock_cnt_ff; // lock delay counter
  logic dll_locked_ff; // lock flag
  // read pipeline: latency countdown then beat shifter
  logic [4:0] lat_cnt_ff; // cycles to first beat
  logic pend_ff; // read waiting for latency
  logic [3:0] beats_left_ff; // beats still to send
  logic [2:0] beat_idx_ff; // current beat index
  logic pend_pat_ff; // pending read is a pattern read
  logic [15:0] pend_word_ff; // array word for pending read
  logic [3:0] pend_beats_ff; // beat count for pending read
  logic [2:0] pend_start_ff; // first beat index
  logic cur_pat_ff; // active burst is pattern
  logic [15:0] cur_word_ff; // active array word
  logic [15:0] dq_o_ff; // lane drive value
  logic dq_oe_n_ff; // lane enable, low drives
  logic dq_valid_ff; // beat valid
  logic [4:0] nxt_lat; // read latency for new read
  logic chop; // decoded chop for this command
  logic is_rd; // read command now

  // burst length decision from mode field and chop line
  function automatic logic chop_of(input logic [1:0] fld, input logic line);
    chop_of = (fld == sprbc_pkg::BL_FIXED4) || ((fld == sprbc_pkg::BL_OTF) && !line); // R8 R20 R22
  endfunction

  // pattern bit for a location; reserved locations read zero
  function automatic logic pat_bit(input logic [1:0] loc, input logic [2:0] idx);
    pat_bit = (loc == sprbc_pkg::LOC_CAL) ? sprbc_pkg::CAL_PATTERN[idx] : 1'b0; // R11 R12
  endfunction

  assign is_rd = (lnk.cmd == sprbc_pkg::CMD_RD);
  assign chop = chop_of(bl_field_ff, lnk.addr[sprbc_pkg::BURST_CHOP_BIT]);
  assign nxt_lat = 5'(add_lat_ff) + 5'(cas_lat_ff); // R23

  // loop lock after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt_ff <= 6'h00;
      dll_locked_ff <= 1'b0;
    end else if (!dll_locked_ff) begin
      lock_cnt_ff <= lock_cnt_ff + 6'h01;
      dll_locked_ff <= (lock_cnt_ff == 6'(LOCK_CYC - 1));
    end
  end

  // mode words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bl_field_ff <= sprbc_pkg::BL_FIXED8;
      cas_lat_ff <= 4'h6;
      add_lat_ff <= 4'h0;
      pat_en_ff <= 1'b0;
      pat_loc_ff <= 2'h0;
    end else if (lnk.cmd == sprbc_pkg::CMD_MRS) begin
      case (lnk.bank)
        sprbc_pkg::MW_ZERO: begin
          bl_field_ff <= lnk.addr[1:0];
          cas_lat_ff <= lnk.addr[7:4];
        end
        sprbc_pkg::MW_ONE: add_lat_ff <= lnk.addr[3:0];
        sprbc_pkg::MW_THREE: begin
          pat_en_ff <= lnk.addr[sprbc_pkg::PAT_EN_BIT];
          pat_loc_ff <= lnk.addr[1:0];
        end
        default: ; // other mode words hold nothing modelled here
      endcase
    end
  end

  // bank open state and close timers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_ff <= '0;
      for (int b = 0; b < sprbc_pkg::BANKS; b++) begin
        row_ff[b] <= 16'h0000;
        close_cnt_ff[b] <= 8'h00;
      end
    end else begin
      for (int b = 0; b < sprbc_pkg::BANKS; b++) begin
        if (close_cnt_ff[b] != 8'h00) close_cnt_ff[b] <= close_cnt_ff[b] - 8'h01;
      end
      if (lnk.cmd == sprbc_pkg::CMD_ACT) begin
        open_ff[lnk.bank] <= 1'b1; // R14
        row_ff[lnk.bank] <= lnk.addr; // R14
      end else if (lnk.cmd == sprbc_pkg::CMD_PRE) begin
        for (int b = 0; b < sprbc_pkg::BANKS; b++) begin
          // all-bank form uses the auto precharge line; idle banks restart too
          if (lnk.addr[sprbc_pkg::AUTO_PRECHARGE_BIT] || (3'(b) == lnk.bank)) begin
            open_ff[b] <= 1'b0; // R16 R19
            close_cnt_ff[b] <= 8'(sprbc_pkg::ROW_CLOSE_CYC); // R16 R19
          end
        end
      end else if ((is_rd || lnk.cmd == sprbc_pkg::CMD_WR) && !pat_en_ff &&
                   lnk.addr[sprbc_pkg::AUTO_PRECHARGE_BIT]) begin
        // auto precharge only closes the addressed bank; others stay usable
        open_ff[lnk.bank] <= 1'b0; // R17
        close_cnt_ff[lnk.bank] <= 8'(sprbc_pkg::ROW_CLOSE_CYC);
      end
    end
  end

  // array writes: column bits below the chop line only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) mem_ff[i] <= 16'h0000;
    end else if (lnk.cmd == sprbc_pkg::CMD_WR && !pat_en_ff) begin
      mem_ff[lnk.addr[6:3]] <= {13'h0000, lnk.bank} ^ row_ff[lnk.bank]; // R21 R24
    end
  end

  // read capture: one pending read, latency from mode words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_ff <= 1'b0;
      lat_cnt_ff <= 5'h00;
      pend_pat_ff <= 1'b0;
      pend_word_ff <= 16'h0000;
      pend_beats_ff <= 4'h0;
      pend_start_ff <= 3'h0;
    end else if (is_rd) begin
      pend_ff <= 1'b1;
      lat_cnt_ff <= (nxt_lat == 5'h00) ? 5'h00 : nxt_lat - 5'h01; // R9
      pend_pat_ff <= pat_en_ff; // R24
      pend_word_ff <= mem_ff[lnk.addr[6:3]]; // R21
      pend_beats_ff <= chop ? 4'(sprbc_pkg::BEATS_CHOP) : 4'(sprbc_pkg::BEATS_FULL); // R20
      // pattern reads keep only column bit two for the nibble
      pend_start_ff <= (chop && lnk.addr[sprbc_pkg::NIBBLE_BIT]) ? 3'h4 : 3'h0; // R4 R6 R7
    end else if (pend_ff) begin
      if (lat_cnt_ff == 5'h00) pend_ff <= 1'b0;
      else lat_cnt_ff <= lat_cnt_ff - 5'h01;
    end
  end

  // beat shifter and lane drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beats_left_ff <= 4'h0;
      beat_idx_ff <= 3'h0;
      cur_pat_ff <= 1'b0;
      cur_word_ff <= 16'h0000;
      dq_o_ff <= 16'h0000;
      dq_oe_n_ff <= 1'b1;
      dq_valid_ff <= 1'b0;
    end else begin
      logic [2:0] idx;
      logic [3:0] left;
      logic pat;
      logic [15:0] word;
      idx = beat_idx_ff;
      left = beats_left_ff;
      pat = cur_pat_ff;
      word = cur_word_ff;
      if (pend_ff && lat_cnt_ff == 5'h00 && beats_left_ff <= 4'h1) begin
        idx = pend_start_ff;
        left = pend_beats_ff;
        pat = pend_pat_ff;
        word = pend_word_ff;
      end
      if (left != 4'h0) begin
        // one bit over every lane, so each byte copies its lane zero
        dq_o_ff <= pat ? {16{pat_bit(pat_loc_ff, idx)}} : word ^ {13'h0000, idx}; // R1 R2 R3
        dq_oe_n_ff <= 1'b0;
        dq_valid_ff <= 1'b1;
        beat_idx_ff <= idx + 3'h1;
        beats_left_ff <= left - 4'h1;
      end else begin
        dq_oe_n_ff <= 1'b1;
        dq_valid_ff <= 1'b0;
        beats_left_ff <= 4'h0;
      end
      cur_pat_ff <= pat;
      cur_word_ff <= word;
    end
  end

  assign lnk.dll_locked = dll_locked_ff;
  assign lnk.dq_dev_o = dq_o_ff;
  assign lnk.dq_dev_oe_n = dq_oe_n_ff;
  assign lnk.dq_valid = dq_valid_ff;
endmodule
`default_nettype wire

// *** verif/sprbc_chk.sv ***
/*
  link checker (read latency, burst length, lane use, pattern content)
  and the bench top that joins both ends and drives the register bus.
  assumes one clock for both ends and steady mode words during reads.
*/
`timescale 1ns/10ps
`default_nettype none
module sprbc_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command side
  input wire logic [2:0] cmd,
  input wire logic [2:0] bank,
  input wire logic [15:0] addr,
  input wire logic dll_locked,
  // data side
  input wire logic dq_dev_oe_n,
  input wire logic dq_valid,
  input wire logic [15:0] dq
);
  logic [1:0] bl_ff; // burst length field
  logic [3:0] cl_ff; // column latency
  logic [3:0] al_ff; // additive latency
  logic pat_ff; // pattern readout on
  logic [1:0] loc_ff; // pattern location
  logic [31:0] full_ff; // full reads, bit n set n+1 cycles after the command
  logic [31:0] chop_ff; // chopped reads, same ages
  logic is_rd; // read on the link now
  logic is_full; // that read is a full burst
  logic [4:0] lat; // programmed read latency
  logic full_due; // first beat of a full read due now
  logic chop_due; // first beat of a chopped read due now
  assign is_rd = (cmd == sprbc_pkg::CMD_RD);
  // fixed eight, or on the fly with the chop line high
  assign is_full = (bl_ff == sprbc_pkg::BL_FIXED8) ||
    ((bl_ff == sprbc_pkg::BL_OTF) && addr[sprbc_pkg::BURST_CHOP_BIT]);
  assign lat = {1'b0, cl_ff} + {1'b0, al_ff};
  // a beat launched lat cycles after the read is first sampled one edge later
  assign full_due = full_ff[lat];
  assign chop_due = chop_ff[lat];
  // shadow of the mode words, kept from the link alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bl_ff <= sprbc_pkg::BL_FIXED8;
      cl_ff <= 4'h6;
      al_ff <= 4'h0;
      pat_ff <= 1'b0;
      loc_ff <= sprbc_pkg::LOC_CAL;
    end else if (cmd == sprbc_pkg::CMD_MRS) begin
      case (bank)
        sprbc_pkg::MW_ZERO: begin
          bl_ff <= addr[1:0];
          cl_ff <= addr[7:4];
        end
        sprbc_pkg::MW_ONE: al_ff <= addr[3:0];
        sprbc_pkg::MW_THREE: begin
          pat_ff <= addr[sprbc_pkg::PAT_EN_BIT];
          loc_ff <= addr[1:0];
        end
        default: ;
      endcase
    end
  end
  // age of each read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_ff <= 32'h0;
      chop_ff <= 32'h0;
    end else begin
      full_ff <= {full_ff[30:0], is_rd && is_full};
      chop_ff <= {chop_ff[30:0], is_rd && !is_full};
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // calibration pattern nibble, lsb beat first
  sequence s_alt4;
    !dq[0] ##1 dq[0] ##1 !dq[0] ##1 dq[0];
  endsequence
  // four beats back to back
  sequence s_beats4;
    dq_valid [*4];
  endsequence

  property p_rd_lat;
    (full_due || chop_due) |-> dq_valid && !$past(dq_valid);
  endproperty
  property p_full_len;
    full_due |-> s_beats4 ##1 s_beats4 ##1 !dq_valid;
  endproperty
  property p_chop_len;
    chop_due |-> s_beats4 ##1 !dq_valid;
  endproperty
  property p_pat_lanes;
    (dq_valid && pat_ff) |->
      (dq == {16{dq[0]}}) || (dq == {7'h00, dq[0], 7'h00, dq[0]});
  endproperty
  property p_pat_full;
    (full_due && pat_ff && loc_ff == sprbc_pkg::LOC_CAL) |-> s_alt4 ##1 s_alt4;
  endproperty
  property p_pat_chop;
    (chop_due && pat_ff && loc_ff == sprbc_pkg::LOC_CAL) |-> s_alt4;
  endproperty
  property p_idle;
    !dq_valid |-> dq_dev_oe_n && (dq == 16'h0000);
  endproperty
  property p_rd_locked;
    is_rd |-> dll_locked && (addr[1:0] == 2'h0);
  endproperty

  a_rd_lat: assert property (p_rd_lat)
    else $error("read beat not at programmed latency");
  a_full_len: assert property (p_full_len)
    else $error("full burst length wrong");
  a_chop_len: assert property (p_chop_len)
    else $error("chopped burst length wrong");
  a_pat_lanes: assert property (p_pat_lanes)
    else $error("pattern lanes disagree");
  a_pat_full: assert property (p_pat_full)
    else $error("full pattern burst content wrong");
  a_pat_chop: assert property (p_pat_chop)
    else $error("chopped pattern burst content wrong");
  a_idle: assert property (p_idle)
    else $error("lanes driven outside a burst");
  a_rd_locked: assert property (p_rd_locked)
    else $error("read sent unlocked or with low column bits set");
endmodule

module sdram_pattern_read_bank_control_test;
  logic aclk = 1'b0; // bench clock, 40 ns
  logic aresetn = 1'b0; // held low for five cycles
  // register bus master side
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  // register bus slave side
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int failures = 0; // mismatches seen
  int n_compared = 0; // comparisons made

  always #20 aclk = ~aclk;

  sprbc_if lnk ();
  sprbc_device u_sprbc_device (.aclk(aclk), .aresetn(aresetn), .lnk(lnk));
  sprbc_ctrl u_sprbc_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .lnk(lnk));
  sprbc_chk u_sprbc_chk (
    .aclk(aclk), .aresetn(aresetn), .cmd(lnk.cmd), .bank(lnk.bank),
    .addr(lnk.addr), .dll_locked(lnk.dll_locked), .dq_dev_oe_n(lnk.dq_dev_oe_n),
    .dq_valid(lnk.dq_valid), .dq(lnk.dq));

  // compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict, the single place where the run ends
  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one write: address and data offered together, each released when taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // one read: request held until taken, data taken with rvalid
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask

  // stage an address, then send one link command
  task automatic issue(input logic [15:0] a, input logic [2:0] cm, input logic [2:0] bk);
    logic [1:0] r;
    axi_write(sprbc_pkg::REG_ADDR, {16'h0000, a}, r);
    check({30'h0, r}, {30'h0, sprbc_pkg::RESP_OKAY});
    axi_write(sprbc_pkg::REG_CMD, {9'h000, bk, 1'b0, cm, 16'h0000}, r);
    check({30'h0, r}, {30'h0, sprbc_pkg::RESP_OKAY});
  endtask

  // full pattern read with default burst field; only location zero is used
  task automatic t_pattern_full;
    logic [31:0] d;
    issue(16'h0004, sprbc_pkg::CMD_MRS, sprbc_pkg::MW_THREE);
    issue(16'h0000, sprbc_pkg::CMD_RD, 3'h5);
    repeat (20) @(posedge aclk);
    axi_read(sprbc_pkg::REG_DATA, d);
    check(d, {24'h000000, sprbc_pkg::CAL_PATTERN});
    axi_read(sprbc_pkg::REG_STATUS, d);
    check({28'h0, d[15:12]}, 32'h00000008);
  endtask

  // chopped pattern read of the upper nibble, chop picked on the fly
  task automatic t_pattern_chop;
    logic [31:0] d;
    issue(16'h0061, sprbc_pkg::CMD_MRS, sprbc_pkg::MW_ZERO);
    issue(16'h0004, sprbc_pkg::CMD_RD, 3'h0);
    repeat (20) @(posedge aclk);
    axi_read(sprbc_pkg::REG_DATA, d);
    check({28'h0, d[3:0]}, {28'h0, sprbc_pkg::CAL_PATTERN[7:4]});
    axi_read(sprbc_pkg::REG_STATUS, d);
    check({28'h0, d[15:12]}, 32'h00000004);
  endtask

  // activate, refused reopen, precharge, refused write, repeat precharge
  task automatic t_banks;
    logic [31:0] d;
    logic [1:0] r;
    issue(16'h0123, sprbc_pkg::CMD_ACT, 3'h2);
    axi_read(sprbc_pkg::REG_STATUS, d);
    check({31'h0, d[6]}, 32'h00000001);
    issue(16'h0456, sprbc_pkg::CMD_ACT, 3'h2);
    axi_read(sprbc_pkg::REG_STATUS, d);
    check({31'h0, d[3]}, 32'h00000001);
    issue(16'h0000, sprbc_pkg::CMD_PRE, 3'h2);
    axi_read(sprbc_pkg::REG_STATUS, d);
    check({30'h0, d[6], d[3]}, 32'h00000000);
    issue(16'h0000, sprbc_pkg::CMD_WR, 3'h2);
    axi_read(sprbc_pkg::REG_STATUS, d);
    check({31'h0, d[3]}, 32'h00000001);
    issue(16'h0000, sprbc_pkg::CMD_PRE, 3'h2);
    axi_read(sprbc_pkg::REG_STATUS, d);
    check({31'h0, d[3]}, 32'h00000000);
    axi_write(sprbc_pkg::REG_STATUS, 32'h00000000, r);
    check({30'h0, r}, {30'h0, sprbc_pkg::RESP_SLVERR});
  endtask

  // pattern off: write then full read from the array
  task automatic t_array;
    logic [31:0] d;
    issue(16'h0000, sprbc_pkg::CMD_MRS, sprbc_pkg::MW_THREE);
    issue(16'h0000, sprbc_pkg::CMD_ACT, 3'h1);
    issue(16'h1000, sprbc_pkg::CMD_WR, 3'h1);
    issue(16'h1000, sprbc_pkg::CMD_RD, 3'h1);
    repeat (20) @(posedge aclk);
    axi_read(sprbc_pkg::REG_DATA, d);
    check(d, 32'h00000055);
    axi_read(sprbc_pkg::REG_STATUS, d);
    check({28'h0, d[15:12]}, 32'h00000008);
  endtask

  // scenario sequence; lock is awaited before any pattern read
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (30) @(posedge aclk);
    t_pattern_full();
    t_pattern_chop();
    t_banks();
    t_array();
    tally_and_finish();
  end

  // watchdog: far beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
